// ### prx_pkg.sv
// Functional notes
// [R1] Emitter-3 drive level sits in bits 3:0; bits 7:4 are reserved.
// [R2] Drive code 0 gives no current, 1 the least and 15 the most.
// [R3] Each channel-1 result is compared with a 16-bit channel-1 threshold.
// [R4] Each channel-2 result is compared with its own 16-bit threshold.
// [R5] Channel-1 threshold bits 7:0 sit in the byte register at 0x11.
// [R6] Channel-1 threshold bits 15:8 sit in the byte register at 0x12.
// [R7] Channel-2 threshold bits 7:0 sit in the byte register at 0x13.
// [R8] Bytes act alone, so a half-written threshold may be compared.
// [R9] The host stops measuring or drops results around threshold changes.
// [R10] The host pauses proximity measurement before changing a threshold.
// [R11] Legacy silicon uses one compressed channel-1 byte at 0x11.
// [R12] Legacy silicon uses one compressed channel-2 byte at 0x13.
// [R13] Reset clears the emitter-3 register and every threshold byte to zero; the channel-2 high byte comes from i_prox2_high_byte and is not cleared.
// [R14] A 16-bit threshold takes its lower-offset byte as its low half.
package prx_pkg;
    localparam logic [7:0]  ADDR_EMITTER3   = 8'h10;
    localparam logic [7:0]  ADDR_P1_LOW     = 8'h11;
    localparam logic [7:0]  ADDR_P1_HIGH    = 8'h12;
    localparam logic [7:0]  ADDR_P2_LOW     = 8'h13;
    localparam logic [7:0]  RESET_BYTE      = 8'h00;
    localparam logic [3:0]  RESET_NIBBLE    = 4'h0;
    localparam logic [15:0] RESET_WORD      = 16'h0000;
    localparam logic [3:0]  RESERVED_READ   = 4'h0;
    localparam int          DRIVE_LSB       = 0;
    localparam int          DRIVE_MSB       = 3;
    localparam int          DRIVE_STEPS     = 15;
    localparam logic [3:0]  DRIVE_OFF       = 4'h0;
    localparam logic [3:0]  DRIVE_MIN       = 4'h1;
    localparam logic [3:0]  DRIVE_MAX       = 4'hF;
    localparam int          COMP_EXP_LSB    = 4;
    localparam int          COMP_MANT_MSB   = 3;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } prx_wr_s;

    typedef struct packed {
        logic        valid;
        logic        chan2;
        logic [15:0] result;
    } prx_meas_s;

    typedef enum logic [1:0] {
        PRX_RD_IDLE = 2'b00,
        PRX_RD_DATA = 2'b01
    } prx_rd_state_e;
endpackage : prx_pkg

// ### prx_led_decode.sv
`timescale 1ns/1ps
module prx_led_decode (
    input  wire logic                                 i_clock,
    input  wire logic                                 i_rst,
    input  wire logic [3:0]                           i_code,
    output logic                                      o_drive_on,
    output logic                                      o_drive_min,
    output logic                                      o_drive_max,
    output logic [prx_pkg::DRIVE_STEPS-1:0]           o_drive_level
);
    import prx_pkg::*;

    logic [DRIVE_STEPS-1:0] level_ff;
    logic [DRIVE_STEPS-1:0] nxt_level;
    logic                   on_ff;
    logic                   min_ff;
    logic                   max_ff;
    logic                   nxt_on;
    logic                   nxt_min;
    logic                   nxt_max;

    // Thermometer code: one current step per leg, so code n turns on n legs
    genvar g;
    generate
        for (g = 0; g < DRIVE_STEPS; g++) begin : g_leg
            assign nxt_level[g] = (i_code > 4'(g)); // [R2]
        end
    endgenerate

    always_comb begin
        nxt_on  = (i_code != DRIVE_OFF); // [R2]
        nxt_min = (i_code == DRIVE_MIN); // [R2]
        nxt_max = (i_code == DRIVE_MAX); // [R2]
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            level_ff <= '0;
            on_ff    <= 1'b0;
            min_ff   <= 1'b0;
            max_ff   <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            on_ff    <= nxt_on;
            min_ff   <= nxt_min;
            max_ff   <= nxt_max;
        end
    end

    assign o_drive_on    = on_ff;
    assign o_drive_min   = min_ff;
    assign o_drive_max   = max_ff;
    assign o_drive_level = level_ff;

    AST_DRIVE_OFF: assert property ( // [R2]
        @(posedge i_clock) disable iff (i_rst)
        (i_code == DRIVE_OFF) |=> (!o_drive_on && o_drive_level == '0))
        else $error("drive active for code zero");
endmodule : prx_led_decode

// ### prx_threshold_third_emitter_pin_regs.sv
`timescale 1ns/1ps
module prx_threshold_third_emitter_pin_regs (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    input  wire prx_pkg::prx_wr_s              i_wr,
    input  wire logic                          i_rd_en,
    input  wire logic [7:0]                    i_rd_addr,
    output logic [7:0]                         o_rd_data,
    output logic                               o_rd_valid,
    input  wire logic                          i_legacy_rev,
    input  wire logic [7:0]                    i_prox2_high_byte,
    input  wire prx_pkg::prx_meas_s            i_meas,
    output logic                               o_ch1_event,
    output logic                               o_ch2_event,
    output logic [15:0]                        o_prox_ch1_threshold,
    output logic [15:0]                        o_prox_ch2_threshold,
    output logic [3:0]                         o_emitter3_drive_level,
    output logic                               o_emitter3_on,
    output logic [prx_pkg::DRIVE_STEPS-1:0]    o_third_emitter_pin_level
);
    import prx_pkg::*;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Register bank
    logic [3:0]    emitter3_drive_level_ff;
    logic [7:0]    prox1_threshold_low_ff;
    logic [7:0]    prox1_threshold_high_ff;
    logic [7:0]    prox2_threshold_low_ff;
    logic [3:0]    nxt_emitter3_drive_level;
    logic [7:0]    nxt_prox1_threshold_low;
    logic [7:0]    nxt_prox1_threshold_high;
    logic [7:0]    nxt_prox2_threshold_low;

    always_comb begin
        nxt_emitter3_drive_level = emitter3_drive_level_ff;
        nxt_prox1_threshold_low  = prox1_threshold_low_ff;
        nxt_prox1_threshold_high = prox1_threshold_high_ff;
        nxt_prox2_threshold_low  = prox2_threshold_low_ff;
        if (i_wr.en) begin
            case (i_wr.addr)
                ADDR_EMITTER3: begin
                    // Upper nibble is reserved, so write data there is dropped
                    nxt_emitter3_drive_level =
                        i_wr.data[DRIVE_MSB:DRIVE_LSB]; // [R1]
                end
                ADDR_P1_LOW:  nxt_prox1_threshold_low  = i_wr.data; // [R5]
                ADDR_P1_HIGH: nxt_prox1_threshold_high = i_wr.data; // [R6]
                ADDR_P2_LOW:  nxt_prox2_threshold_low  = i_wr.data; // [R7]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            emitter3_drive_level_ff <= RESET_NIBBLE; // [R13]
            prox1_threshold_low_ff  <= RESET_BYTE;   // [R13]
            prox1_threshold_high_ff <= RESET_BYTE;   // [R13]
            prox2_threshold_low_ff  <= RESET_BYTE;   // [R13]
        end else begin
            emitter3_drive_level_ff <= nxt_emitter3_drive_level;
            prox1_threshold_low_ff  <= nxt_prox1_threshold_low;
            prox1_threshold_high_ff <= nxt_prox1_threshold_high;
            prox2_threshold_low_ff  <= nxt_prox2_threshold_low;
        end
    end

    // Read path: one-cycle registered answer
    prx_rd_state_e rd_state_ff;
    prx_rd_state_e nxt_rd_state;
    logic [7:0]    rd_data_ff;
    logic [7:0]    nxt_rd_data;

    always_comb begin
        nxt_rd_data  = rd_data_ff;
        nxt_rd_state = PRX_RD_IDLE;
        if (i_rd_en) begin
            nxt_rd_state = PRX_RD_DATA;
            case (i_rd_addr)
                ADDR_EMITTER3: nxt_rd_data =
                    {RESERVED_READ, emitter3_drive_level_ff}; // [R1]
                ADDR_P1_LOW:   nxt_rd_data = prox1_threshold_low_ff;
                ADDR_P1_HIGH:  nxt_rd_data = prox1_threshold_high_ff;
                ADDR_P2_LOW:   nxt_rd_data = prox2_threshold_low_ff;
                default:       nxt_rd_data = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rd_state_ff <= PRX_RD_IDLE;
            rd_data_ff  <= RESET_BYTE;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    assign o_rd_data  = rd_data_ff;
    assign o_rd_valid = (rd_state_ff == PRX_RD_DATA);

    // Compressed byte: upper nibble is a shift, lower nibble the mantissa
    function automatic logic [15:0] expand(input logic [7:0] c);
        logic [15:0] m;
        m = {12'h000, c[COMP_MANT_MSB:0]};
        return m << c[7:COMP_EXP_LSB];
    endfunction

    // Bytes are used live, so a half-finished host update is seen as is;
    // the host is expected to pause measurement around updates.
    logic [15:0] thr1;
    logic [15:0] thr2;
    always_comb begin
        if (i_legacy_rev) begin
            thr1 = expand(prox1_threshold_low_ff); // [R11]
            thr2 = expand(prox2_threshold_low_ff); // [R12]
        end else begin
            thr1 = {prox1_threshold_high_ff,
                    prox1_threshold_low_ff}; // [R14] [R8]
            thr2 = {i_prox2_high_byte,
                    prox2_threshold_low_ff}; // [R14] [R8]
        end
    end

    logic        ch1_event_ff;
    logic        ch2_event_ff;
    logic        nxt_ch1_event;
    logic        nxt_ch2_event;

    always_comb begin
        nxt_ch1_event = i_meas.valid && !i_meas.chan2
                        && (i_meas.result > thr1); // [R3]
        nxt_ch2_event = i_meas.valid && i_meas.chan2
                        && (i_meas.result > thr2); // [R4]
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ch1_event_ff <= 1'b0;
            ch2_event_ff <= 1'b0;
        end else begin
            ch1_event_ff <= nxt_ch1_event;
            ch2_event_ff <= nxt_ch2_event;
        end
    end

    assign o_ch1_event            = ch1_event_ff;
    assign o_ch2_event            = ch2_event_ff;
    assign o_prox_ch1_threshold   = thr1;
    assign o_prox_ch2_threshold   = thr2;
    assign o_emitter3_drive_level = emitter3_drive_level_ff;

    prx_led_decode u_third_emitter_pin (
        .i_clock       (i_clock),
        .i_rst         (i_rst),
        .i_code        (emitter3_drive_level_ff),
        .o_drive_on    (o_emitter3_on),
        .o_drive_min   (),
        .o_drive_max   (),
        .o_drive_level (o_third_emitter_pin_level)
    );

    AST_RESET_CLEAR: assert property ( // [R13]
        @(posedge i_clock) disable iff (1'b0)
        i_rst |=> (o_emitter3_drive_level == RESET_NIBBLE
                   && o_prox_ch1_threshold == RESET_WORD
                   && prox2_threshold_low_ff == RESET_BYTE
                   && !o_rd_valid && !o_ch1_event && !o_ch2_event))
        else $error("registers not cleared by reset");

    AST_EMITTER_NIBBLE: assert property ( // [R1]
        (i_wr.en && i_wr.addr == ADDR_EMITTER3) |=>
        o_emitter3_drive_level == $past(i_wr.data[DRIVE_MSB:DRIVE_LSB]))
        else $error("emitter level not written from low nibble");

    AST_RESERVED_ZERO: assert property ( // [R1]
        (i_rd_en && i_rd_addr == ADDR_EMITTER3) |=>
        (o_rd_valid && o_rd_data[7:4] == RESERVED_READ))
        else $error("reserved bits read nonzero");

    AST_P1_LOW_MAP: assert property ( // [R5]
        (i_wr.en && i_wr.addr == ADDR_P1_LOW && !i_legacy_rev)
        ##1 !i_legacy_rev |->
        o_prox_ch1_threshold[7:0] == $past(i_wr.data))
        else $error("channel-1 low byte misplaced");

    AST_P1_HIGH_MAP: assert property ( // [R6]
        (i_wr.en && i_wr.addr == ADDR_P1_HIGH)
        ##1 !i_legacy_rev |->
        o_prox_ch1_threshold[15:8] == $past(i_wr.data))
        else $error("channel-1 high byte misplaced");

    AST_P2_LOW_MAP: assert property ( // [R7]
        (i_wr.en && i_wr.addr == ADDR_P2_LOW) ##2
        (i_rd_en && i_rd_addr == ADDR_P2_LOW) ##0
        !$past(i_wr.en, 1) |=> o_rd_data == $past(i_wr.data, 3))
        else $error("channel-2 low byte not read back");

    AST_CH1_EVENT: assert property ( // [R3]
        (i_meas.valid && !i_meas.chan2 && i_meas.result > thr1) |=>
        o_ch1_event ##1 1'b1)
        else $error("channel-1 crossing missed");

    AST_CH2_EVENT: assert property ( // [R4]
        o_ch2_event |-> $past(i_meas.valid && i_meas.chan2
                              && i_meas.result > thr2))
        else $error("channel-2 event without crossing");

    AST_LEGACY_CH1: assert property ( // [R11]
        (i_legacy_rev && prox1_threshold_low_ff == 8'h01) |->
        thr1 == 16'h0001)
        else $error("legacy channel-1 threshold not expanded");

    AST_LEGACY_CH2: assert property ( // [R12]
        (i_legacy_rev && prox2_threshold_low_ff == 8'h01) |->
        thr2 == 16'h0001)
        else $error("legacy channel-2 threshold not expanded");

    AST_UNMAPPED_READ: assert property (
        (i_rd_en && i_rd_addr > ADDR_P2_LOW) |=> o_rd_data == RESET_BYTE)
        else $error("unmapped read not zero");
endmodule : prx_threshold_third_emitter_pin_regs

// ### prx_host_model.sv
`timescale 1ns/1ps
module prx_host_model (
    input  wire logic           i_clock,
    output prx_pkg::prx_wr_s    o_wr,
    output logic                o_rd_en,
    output logic [7:0]          o_rd_addr,
    input  wire logic [7:0]     i_rd_data,
    input  wire logic           i_rd_valid
);
    import prx_pkg::*;
    initial begin
        o_wr = '0;
        o_rd_en = 1'b0;
        o_rd_addr = 8'h00;
    end
    // Byte writes; callers keep measurement pulses idle around them
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_wr <= {1'b1, a, d};
        @(negedge i_clock);
        // Released fields show the inverse so stale values never match
        o_wr <= {1'b0, ~a, ~d};
    endtask : wr_byte
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] q,
                           output logic ok);
        ok = 1'b0;
        @(negedge i_clock);
        o_rd_en <= 1'b1;
        o_rd_addr <= a;
        for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
            @(negedge i_clock);
            o_rd_en <= 1'b0;
            o_rd_addr <= ~a;
            if (i_rd_valid === 1'b1) begin
                ok = 1'b1;
                q = i_rd_data;
            end
        end
    endtask : rd_byte
endmodule : prx_host_model

// ### prx_threshold_third_emitter_pin_regs_tb_top.sv
`timescale 1ns/1ps
module prx_threshold_third_emitter_pin_regs_tb_top;
    import prx_pkg::*;
    logic                   i_clock;
    logic                   i_rst;
    prx_wr_s                i_wr;
    logic                   i_rd_en;
    logic [7:0]             i_rd_addr;
    logic [7:0]             o_rd_data;
    logic                   o_rd_valid;
    logic                   i_legacy_rev;
    logic [7:0]             i_prox2_high_byte;
    prx_meas_s              i_meas;
    logic                   o_ch1_event;
    logic                   o_ch2_event;
    logic [15:0]            o_prox_ch1_threshold;
    logic [15:0]            o_prox_ch2_threshold;
    logic [3:0]             o_emitter3_drive_level;
    logic                   o_emitter3_on;
    logic [DRIVE_STEPS-1:0] o_third_emitter_pin_level;
    logic [7:0]             s;
    logic [7:0]             a;
    logic [7:0]             q;
    logic [7:0]             rg [4];
    logic [15:0]            t1;
    logic [15:0]            t2;
    int                     failures;
    int                     n_checks;

    prx_threshold_third_emitter_pin_regs DUT (
        .i_clock(i_clock), .i_rst(i_rst), .i_wr(i_wr),
        .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .i_legacy_rev(i_legacy_rev),
        .i_prox2_high_byte(i_prox2_high_byte), .i_meas(i_meas),
        .o_ch1_event(o_ch1_event), .o_ch2_event(o_ch2_event),
        .o_prox_ch1_threshold(o_prox_ch1_threshold),
        .o_prox_ch2_threshold(o_prox_ch2_threshold),
        .o_emitter3_drive_level(o_emitter3_drive_level),
        .o_emitter3_on(o_emitter3_on),
        .o_third_emitter_pin_level(o_third_emitter_pin_level)
    );
    prx_host_model HOST (
        .i_clock(i_clock), .o_wr(i_wr), .o_rd_en(i_rd_en),
        .o_rd_addr(i_rd_addr), .i_rd_data(o_rd_data),
        .i_rd_valid(o_rd_valid)
    );

    always #5 i_clock = ~i_clock;

    function automatic logic [7:0] lfsr(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    function automatic logic [15:0] thr(logic [7:0] lo, logic [7:0] hi,
                                        logic leg);
        if (leg) return 16'(lo[3:0]) << lo[7:4];
        return {hi, lo};
    endfunction : thr
    function automatic logic [15:0] therm(int c);
        return (16'h1 << c) - 16'h1;
    endfunction : therm
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(logic [7:0] ad, logic [7:0] e);
        logic ok;
        HOST.rd_byte(ad, q, ok);
        if (ok !== 1'b1) begin
            failures++;
            end_of_test();
        end else begin
            chk("rd_data", {8'h00, e}, {8'h00, q});
        end
    endtask : rd
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        // No measurement pulse overlaps a write: the pause the host owes
        HOST.wr_byte(ad, d);
        rg[ad[1:0]] = (ad == ADDR_EMITTER3) ? {4'h0, d[3:0]} : d;
    endtask : wr
    task automatic meas(logic c2, logic [15:0] r, logic e);
        @(negedge i_clock);
        i_meas <= {1'b1, c2, r};
        @(negedge i_clock);
        i_meas <= {1'b0, ~c2, ~r};
        chk("ch1_event", {15'h0, e & ~c2}, {15'h0, o_ch1_event});
        chk("ch2_event", {15'h0, e & c2}, {15'h0, o_ch2_event});
    endtask : meas
    // Strict compare: one above the threshold fires, equal does not
    task automatic evt(logic c2, logic [15:0] t);
        if (t !== 16'hFFFF) meas(c2, t + 16'h1, 1'b1);
        meas(c2, t, 1'b0);
    endtask : evt

    initial begin
        #200us;
        failures++;
        end_of_test();
    end
    initial begin
        i_clock = 1'b0;
        i_rst = 1'b1;
        i_legacy_rev = 1'b0;
        i_prox2_high_byte = 8'h00;
        i_meas = '0;
        s = 8'd28;
        failures = 0;
        n_checks = 0;
        foreach (rg[k]) rg[k] = 8'h00;
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_rst <= 1'b0;
        // Offset 0x14 lies outside the block and must read as zero
        for (int k = 0; k < 5; k++) rd(8'h10 + 8'(k), 8'h00);
        chk("pin", 16'h0, {1'b0, o_third_emitter_pin_level});
        evt(1'b0, 16'h0);
        for (int c = 0; c < 16; c++) begin
            s = lfsr(s);
            wr(ADDR_EMITTER3, {s[7:4], 4'(c)});
            @(negedge i_clock);
            chk("level", 16'(c), {12'h0, o_emitter3_drive_level});
            chk("on", 16'(c != 0), {15'h0, o_emitter3_on});
            chk("pin", therm(c), {1'b0, o_third_emitter_pin_level});
            rd(ADDR_EMITTER3, 8'(c));
        end
        wr(ADDR_P1_LOW, 8'hFF);
        wr(ADDR_P1_HIGH, 8'hFF);
        evt(1'b0, 16'hFFFF);
        // Legacy byte 0x01 is mantissa 1 with no shift
        i_legacy_rev <= 1'b1;
        wr(ADDR_P1_LOW, 8'h01);
        wr(ADDR_P2_LOW, 8'h01);
        chk("leg_thr1", 16'h0001, o_prox_ch1_threshold);
        chk("leg_thr2", 16'h0001, o_prox_ch2_threshold);
        evt(1'b1, 16'h0001);
        for (int n = 0; n < 30; n++) begin
            s = lfsr(s);
            a = ADDR_P1_LOW + (s % 8'd3);
            s = lfsr(s);
            i_legacy_rev <= s[0];
            i_prox2_high_byte <= ~s;
            wr(a, lfsr(s));
            t1 = thr(rg[1], rg[2], i_legacy_rev);
            t2 = thr(rg[3], i_prox2_high_byte, i_legacy_rev);
            chk("ch1_thr", t1, o_prox_ch1_threshold);
            chk("ch2_thr", t2, o_prox_ch2_threshold);
            rd(a, rg[a[1:0]]);
            evt(1'b0, t1);
            evt(1'b1, t2);
        end
        // Reset again with loaded registers so the clear is really seen
        wr(ADDR_EMITTER3, 8'h0F);
        @(negedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(negedge i_clock);
        i_rst <= 1'b0;
        for (int k = 0; k < 4; k++) rd(ADDR_EMITTER3 + 8'(k), 8'h00);
        chk("pin", 16'h0, {1'b0, o_third_emitter_pin_level});
        end_of_test();
    end
endmodule : prx_threshold_third_emitter_pin_regs_tb_top
